// File: ecp_pkg.sv
`default_nettype none
package ecp_pkg;
   // mode field encodings
   localparam logic [2:0] MODE_STD    = 3'h0;
   localparam logic [2:0] MODE_BIDIR  = 3'h1;
   localparam logic [2:0] MODE_PFIFO  = 3'h2;
   localparam logic [2:0] MODE_ECP    = 3'h3;
   localparam logic [2:0] MODE_TEST   = 3'h6;
   // fifo shape: one command flag above the data byte
   localparam int         FIFO_DEPTH  = 16;
   localparam int         FIFO_WIDTH  = 9;
   localparam int         CMD_BIT     = 8;
   localparam logic [4:0] FIFO_FULL   = 5'h10;
   localparam logic [4:0] THR_CAP     = 5'h0f;
   // dma pacing and request framing
   localparam logic [5:0] DMA_BURST_MAX = 6'h20;
   localparam logic [2:0] LDRQ_BITS     = 3'h5;
   // reset values
   localparam logic [2:0] MODE_RST    = MODE_STD;
   localparam logic       MASK_RST    = 1'b1;
   localparam logic       DIR_RST     = 1'b0;
endpackage : ecp_pkg
`default_nettype wire

// File: ecp_fifo_if.sv
`default_nettype none
interface ecp_fifo_if;
   logic       push;
   logic [8:0] wdata;
   logic       pop;
   logic       flush;
   logic [8:0] rdata;
   logic [4:0] count;
   logic       full;
   logic       empty;
   modport store (input push, wdata, pop, flush,
                  output rdata, count, full, empty);
   modport user  (output push, wdata, pop, flush,
                  input rdata, count, full, empty);
endinterface : ecp_fifo_if
`default_nettype wire

// File: ecp_fifo.sv
`default_nettype none
module ecp_fifo
   import ecp_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic   i_clk,   // port clock
   input  wire logic   i_srst,  // sync reset, high
   ecp_fifo_if.store   bus      // push/pop side
);
   logic [FIFO_WIDTH-1:0] mem_reg [DEPTH];
   logic [3:0]            wr_reg;
   logic [3:0]            rd_reg;
   logic [4:0]            cnt_reg;
   logic                  do_push;
   logic                  do_pop;

   // overflow and underflow are dropped so no caller ever waits
   assign do_push = bus.push && !bus.full;   // R8
   assign do_pop  = bus.pop && !bus.empty;

   // pointers and occupancy; flush empties it
   always_ff @(posedge i_clk) begin
      if (i_srst || bus.flush) begin   // R17
         wr_reg  <= 4'h0;
         rd_reg  <= 4'h0;
         cnt_reg <= 5'h00;
      end else begin
         if (do_push) wr_reg <= wr_reg + 4'h1;
         if (do_pop)  rd_reg <= rd_reg + 4'h1;
         if (do_push && !do_pop) cnt_reg <= cnt_reg + 5'h01;   // R24
         else if (do_pop && !do_push) cnt_reg <= cnt_reg - 5'h01;
      end
   end

   // storage, no reset needed
   always_ff @(posedge i_clk) begin
      if (do_push) mem_reg[wr_reg] <= bus.wdata;
   end

   assign bus.rdata = mem_reg[rd_reg];
   assign bus.count = cnt_reg;
   assign bus.full  = (cnt_reg == FIFO_FULL);
   assign bus.empty = (cnt_reg == 5'h00);

   property p_count_bound;
      @(posedge i_clk) disable iff (i_srst)
      cnt_reg <= FIFO_FULL;
   endproperty
   a_count_bound: assert property (p_count_bound)   // R24
      else $error("fifo occupancy above depth");

   property p_flush_empty;
      @(posedge i_clk) disable iff (i_srst)
      bus.flush |=> bus.empty && (cnt_reg == 5'h00);
   endproperty
   a_flush_empty: assert property (p_flush_empty)   // R17
      else $error("fifo not empty after flush");
endmodule : ecp_fifo
`default_nettype wire

// File: ecp_port.sv
// Summary of operation
// [R1] leave ecp mode only while running forward; reverse must turn first
// [R2] forward: hostack high for data bytes, low for command bytes
// [R3] forward command bit 7: 0 run-length count, 1 channel address
// [R4] reverse: periphack high data, low command; reverse addresses unsupported
// [R5] reverse run-length count n repeats next data byte n+1 times
// [R6] software writes count to command port, then byte to data port
// [R7] strobe, autofd, init, selectin open-drain in mode 000, else push-pull
// [R8] dma transfers byte wide; host access never stalls
// [R9] mask bit 1 blocks dma requests and service interrupts
// [R10] clearing mask with condition valid interrupts at once
// [R11] terminal count while enabled interrupts and sets mask bit
// [R12] forward pio interrupt while occupancy at or below threshold
// [R13] reverse pio interrupt while occupancy at least 16 minus threshold
// [R14] fault interrupt on falling fault or enable dropping during fault
// [R15] ack interrupt on rising acknowledge when enabled
// [R16] threshold is field plus one; sixteen treated as fifteen
// [R17] fifo disabled after reset; used only in fifo or ecp mode; the code also enables it in test mode 110
// [R18] dma request held for at most 32 consecutive dma cycles
// [R19] reverse dma requests while data; after tc waits for mask clear
// [R20] dma request signalled on encoded ldrq line; cycle hits fifo
// [R21] software pauses dma: controller off, mask set, dma off
// [R22] pio: data and test ports at 400h, command port at 000h
// [R23] writing mode 011 or 010 starts automatic transfer
// [R24] sixteen-byte fifo with occupancy count for all flow decisions
`default_nettype none
module ecp_port
   import ecp_pkg::*;
#(
   parameter logic [2:0] DMA_CHANNEL = 3'h3
) (
   input  wire logic       i_clk,                // lpc clock
   input  wire logic       i_srst,               // sync reset, high
   input  wire logic [2:0] i_mode,               // requested mode field
   input  wire logic       i_direction,          // 1 = reverse
   input  wire logic       i_mask_wr,            // mask write strobe
   input  wire logic       i_mask_wdata,         // mask write value
   input  wire logic       i_dma_request_enable, // dma enable bit
   input  wire logic [3:0] i_fifo_threshold_field, // threshold minus one
   input  wire logic       i_fault_intr_enable_low, // fault irq enable
   input  wire logic       i_ack_intr_enable,    // ack irq enable
   input  wire logic       i_strobe_sw_n,        // strobe in sw modes
   input  wire logic       i_autofd_sw_n,        // autofd in sw modes
   input  wire logic       i_init_n,             // init value
   input  wire logic       i_select_in_n,        // selectin value
   input  wire logic       i_data_fifo_port_wr,  // write at 400h
   input  wire logic       i_test_fifo_port_wr,  // test write at 400h
   input  wire logic       i_command_fifo_port_wr, // write at 000h
   input  wire logic [7:0] i_wdata,              // host write byte
   input  wire logic       i_fifo_rd,            // read at 400h
   input  wire logic       i_dma_cyc,            // dma cycle strobe
   input  wire logic [7:0] i_dma_wdata,          // dma write byte
   input  wire logic       i_dma_tc,             // terminal count
   input  wire logic [7:0] i_pdata,              // data pins in
   input  wire logic       i_busy,               // periphack/busy pin
   input  wire logic       i_peripheral_ack_low, // ack pin
   input  wire logic       i_peripheral_fault_low, // fault pin
   output logic [7:0]      o_rdata,              // host or dma read byte
   output logic            o_service_intr_mask,  // mask bit state
   output logic            o_service_intr,       // service irq level
   output logic            o_fault_intr,         // fault irq pulse
   output logic            o_ack_intr,           // ack irq pulse
   output logic            o_dma_req,            // dma request level
   output logic            o_ldrq_n,             // encoded request
   output logic [4:0]      o_fifo_count,         // occupancy
   output logic            o_fifo_empty,         // fifo empty
   output logic            o_fifo_full,          // fifo full
   output logic [7:0]      o_pdata,              // data pins out
   output logic            o_pdata_oe,           // data pins enable
   output logic            o_strobe_out,         // strobe pin out
   output logic            o_strobe_oe,          // strobe pin enable
   output logic            o_autofd_out,         // autofd/hostack out
   output logic            o_autofd_oe,          // autofd enable
   output logic            o_init_out,           // init pin out
   output logic            o_init_oe,            // init enable
   output logic            o_select_in_out,      // selectin pin out
   output logic            o_select_in_oe        // selectin enable
);
   typedef enum logic [3:0] {
      F_IDLE = 4'h1, F_SETUP = 4'h2, F_STB = 4'h4, F_REL = 4'h8
   } ecp_fwd_t;
   typedef enum logic [3:0] {
      R_WAIT = 4'h1, R_PUSH = 4'h2, R_END = 4'h4, R_HOLD = 4'h8
   } ecp_rev_t;

   // effective threshold: sixteen collapses onto fifteen
   function automatic logic [4:0] eff_threshold(input logic [3:0] f);
      eff_threshold = (f == 4'hf) ? THR_CAP : {1'b0, f} + 5'h01;  // R16
   endfunction : eff_threshold

   // open-drain drives only low; push-pull always drives
   function automatic logic [1:0] pin_drive(input logic v,
                                            input logic od);
      pin_drive = od ? {1'b0, !v} : {v, 1'b1};   // R7
   endfunction : pin_drive

   ecp_fifo_if fifo ();
   ecp_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .bus    (fifo.store)
   );

   logic [2:0]  mode_reg;
   logic        dir_reg;
   logic        mask_reg;
   logic [10:0] sync1_reg;
   logic [10:0] sync2_reg;
   logic        ack_d_reg;
   logic        fault_d_reg;
   logic        fault_en_d_reg;
   ecp_fwd_t    fwd_reg;
   ecp_rev_t    rev_reg;
   logic [7:0]  fwd_data_reg;
   logic        fwd_hack_reg;
   logic        fwd_stb_n_reg;
   logic [7:0]  rev_byte_reg;
   logic        rev_cmd_reg;
   logic        rev_hack_reg;
   logic [6:0]  rle_cnt_reg;
   logic        rle_pend_reg;
   logic [6:0]  rep_reg;
   logic [5:0]  burst_reg;
   logic        ldrq_sent_reg;
   logic [2:0]  ldrq_cnt_reg;
   logic [4:0]  ldrq_sh_reg;
   logic        ldrq_n_reg;
   logic [7:0]  rdata_reg;
   logic        svc_reg;
   logic        fault_irq_reg;
   logic        ack_irq_reg;
   logic [9:0]  pins_reg;
   logic        busy_s, ack_s, fault_s;
   logic [7:0]  pdata_s;
   logic        fifo_on, xfer_on, ecp_on, mode_ok;
   logic        fwd_pop, rev_push, dma_wr, dma_rd, host_wr, host_rd;
   logic        tc_hit, dma_base, dma_want, dma_req;
   logic        svc_cond;
   logic [4:0]  thr;

   // mode and direction; a reverse ecp channel cannot be left
   assign mode_ok = (mode_reg == MODE_STD) || (mode_reg == MODE_BIDIR) ||
                    (i_mode == MODE_STD) || (i_mode == MODE_BIDIR);
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         mode_reg <= MODE_RST;
         dir_reg  <= DIR_RST;
      end else begin
         if (mode_ok && !(mode_reg == MODE_ECP && dir_reg))   // R1
            mode_reg <= i_mode;
         if (mode_reg == MODE_BIDIR) dir_reg <= i_direction;
      end
   end

   assign fifo_on = (mode_reg == MODE_PFIFO) || (mode_reg == MODE_ECP) ||
                    (mode_reg == MODE_TEST);   // R17
   assign xfer_on = (mode_reg == MODE_PFIFO) || (mode_reg == MODE_ECP);  // R23
   assign ecp_on  = (mode_reg == MODE_ECP);

   // pin synchronisers; first stage feeds only the second
   always_ff @(posedge i_clk) begin
      sync1_reg <= {i_busy, i_peripheral_ack_low,
                    i_peripheral_fault_low, i_pdata};
      sync2_reg <= sync1_reg;
   end
   assign {busy_s, ack_s, fault_s, pdata_s} = sync2_reg;

   // forward engine: fifo head to the peripheral
   assign fwd_pop = (fwd_reg == F_IDLE) && xfer_on && !dir_reg &&
                    !fifo.empty;
   always_ff @(posedge i_clk) begin
      if (i_srst || !xfer_on || dir_reg) begin
         fwd_reg       <= F_IDLE;
         fwd_stb_n_reg <= 1'b1;
         fwd_hack_reg  <= 1'b1;
         fwd_data_reg  <= 8'h00;
      end else begin
         case (fwd_reg)
            F_IDLE: if (fwd_pop) begin
               fwd_data_reg <= fifo.rdata[7:0];   // R3
               // command bytes go out with hostack low
               fwd_hack_reg <= !(ecp_on && fifo.rdata[CMD_BIT]);   // R2
               fwd_reg      <= F_SETUP;
            end
            F_SETUP: begin
               fwd_stb_n_reg <= 1'b0;
               fwd_reg       <= F_STB;
            end
            F_STB: if (busy_s) begin
               fwd_stb_n_reg <= 1'b1;
               fwd_reg       <= F_REL;
            end
            F_REL: if (!busy_s) fwd_reg <= F_IDLE;
            default: fwd_reg <= F_IDLE;
         endcase
      end
   end

   // reverse engine with run-length expansion
   assign rev_push = (rev_reg == R_PUSH) && !rev_cmd_reg && !fifo.full;
   always_ff @(posedge i_clk) begin
      // leaving ecp drops hostack whatever the handshake state
      if (i_srst || !ecp_on || !dir_reg) begin
         rev_reg      <= R_WAIT;
         rev_hack_reg <= 1'b0;
         rev_byte_reg <= 8'h00;
         rev_cmd_reg  <= 1'b0;
         rle_cnt_reg  <= 7'h00;
         rle_pend_reg <= 1'b0;
         rep_reg      <= 7'h00;
      end else begin
         case (rev_reg)
            R_WAIT: if (!ack_s) begin
               rev_byte_reg <= pdata_s;
               rev_cmd_reg  <= !busy_s;   // R4
               rep_reg      <= rle_pend_reg ? rle_cnt_reg : 7'h00;  // R5
               rev_reg      <= R_PUSH;
            end
            R_PUSH: begin
               if (rev_cmd_reg) begin
                  // channel addresses are ignored
                  if (!rev_byte_reg[7]) begin   // R4
                     rle_cnt_reg  <= rev_byte_reg[6:0];
                     rle_pend_reg <= 1'b1;
                  end
                  rev_reg <= R_HOLD;
               end else if (!fifo.full) begin
                  if (rep_reg == 7'h00) begin
                     rle_pend_reg <= 1'b0;
                     rev_reg      <= R_HOLD;
                  end else begin
                     rep_reg <= rep_reg - 7'h01;   // R5
                  end
               end
            end
            R_HOLD: begin
               rev_hack_reg <= 1'b1;
               rev_reg      <= R_END;
            end
            R_END: if (ack_s) begin
               rev_hack_reg <= 1'b0;
               rev_reg      <= R_WAIT;
            end
            default: rev_reg <= R_WAIT;
         endcase
      end
   end

   // host and dma access; drops rather than waits
   assign dma_wr  = i_dma_cyc && !dir_reg && fifo_on;   // R20
   assign dma_rd  = i_dma_cyc && dir_reg && fifo_on;
   assign host_wr = ((i_data_fifo_port_wr && !dir_reg && xfer_on) ||
                     (i_test_fifo_port_wr && mode_reg == MODE_TEST) ||
                     (i_command_fifo_port_wr && ecp_on && !dir_reg));  // R22
   assign host_rd = i_fifo_rd && fifo_on && (dir_reg ||
                    mode_reg == MODE_TEST);
   always_comb begin
      fifo.push  = 1'b0;
      fifo.wdata = 9'h000;
      if (rev_push) begin
         fifo.push  = 1'b1;
         fifo.wdata = {1'b0, rev_byte_reg};
      end else if (dma_wr) begin
         fifo.push  = 1'b1;
         fifo.wdata = {1'b0, i_dma_wdata};   // R8
      end else if (host_wr) begin
         fifo.push  = 1'b1;
         fifo.wdata = {i_command_fifo_port_wr, i_wdata};
      end
   end
   assign fifo.pop   = fwd_pop || dma_rd || host_rd;
   assign fifo.flush = !fifo_on;   // R17

   // read byte; an empty fifo answers zero at once
   always_ff @(posedge i_clk) begin
      if (i_srst) rdata_reg <= 8'h00;
      else if (dma_rd || host_rd)
         rdata_reg <= fifo.empty ? 8'h00 : fifo.rdata[7:0];   // R8
   end

   // service mask; hardware set wins over a software write
   assign tc_hit = i_dma_tc && !mask_reg && i_dma_request_enable;
   always_ff @(posedge i_clk) begin
      if (i_srst) mask_reg <= MASK_RST;
      else if (tc_hit) mask_reg <= 1'b1;   // R11
      else if (i_mask_wr) mask_reg <= i_mask_wdata;
   end

   // dma pacing; masked after tc until software clears it
   assign dma_base = i_dma_request_enable && !mask_reg && fifo_on;  // R9
   assign dma_want = dir_reg ? !fifo.empty : !fifo.full;   // R19
   assign dma_req  = dma_base && dma_want && (burst_reg != DMA_BURST_MAX);
   always_ff @(posedge i_clk) begin
      // one idle cycle after 32 grants lets refresh in
      if (i_srst || !(dma_base && dma_want) ||
          burst_reg == DMA_BURST_MAX)
         burst_reg <= 6'h00;   // R18
      else if (i_dma_cyc)
         burst_reg <= burst_reg + 6'h01;
   end

   // ldrq frame: start, channel msb first, active bit
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ldrq_sent_reg <= 1'b0;
         ldrq_cnt_reg  <= 3'h0;
         ldrq_sh_reg   <= 5'h1f;
         ldrq_n_reg    <= 1'b1;
      end else if (ldrq_cnt_reg != 3'h0) begin
         ldrq_n_reg   <= ldrq_sh_reg[4];
         ldrq_sh_reg  <= {ldrq_sh_reg[3:0], 1'b1};
         ldrq_cnt_reg <= ldrq_cnt_reg - 3'h1;
      end else begin
         ldrq_n_reg <= 1'b1;
         if (dma_req != ldrq_sent_reg) begin   // R20
            ldrq_sh_reg   <= {1'b0, DMA_CHANNEL, dma_req};
            ldrq_cnt_reg  <= LDRQ_BITS;
            ldrq_sent_reg <= dma_req;
         end
      end
   end

   // service level: mask release re-raises a standing condition
   assign thr = eff_threshold(i_fifo_threshold_field);
   assign svc_cond = !mask_reg && !i_dma_request_enable && xfer_on &&
                     (dir_reg ? (fifo.count >= FIFO_FULL - thr)    // R13
                              : (fifo.count <= thr));              // R12
   always_ff @(posedge i_clk) begin
      if (i_srst) svc_reg <= 1'b0;
      else svc_reg <= svc_cond || tc_hit;   // R10
   end

   // fault and ack edge interrupts
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ack_d_reg      <= 1'b1;
         fault_d_reg    <= 1'b1;
         fault_en_d_reg <= 1'b1;
         fault_irq_reg  <= 1'b0;
         ack_irq_reg    <= 1'b0;
      end else begin
         ack_d_reg      <= ack_s;
         fault_d_reg    <= fault_s;
         fault_en_d_reg <= i_fault_intr_enable_low;
         fault_irq_reg  <= !i_fault_intr_enable_low && !fault_s &&
                           (fault_d_reg || fault_en_d_reg);   // R14
         ack_irq_reg    <= i_ack_intr_enable && ack_s && !ack_d_reg;  // R15
      end
   end

   // pin stage; engines own strobe and hostack in transfer modes
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         pins_reg <= 10'h000;
      end else begin
         pins_reg[9:8] <= pin_drive(xfer_on ? fwd_stb_n_reg : i_strobe_sw_n,
                                    mode_reg == MODE_STD);
         pins_reg[7:6] <= pin_drive(!xfer_on ? i_autofd_sw_n :
                                    (dir_reg ? rev_hack_reg : fwd_hack_reg),
                                    mode_reg == MODE_STD);
         pins_reg[5:4] <= pin_drive(i_init_n, mode_reg == MODE_STD);
         pins_reg[3:2] <= pin_drive(i_select_in_n, mode_reg == MODE_STD);
         pins_reg[1]   <= !dir_reg;
         pins_reg[0]   <= 1'b0;
      end
   end

   assign {o_strobe_out, o_strobe_oe}       = pins_reg[9:8];
   assign {o_autofd_out, o_autofd_oe}       = pins_reg[7:6];
   assign {o_init_out, o_init_oe}           = pins_reg[5:4];
   assign {o_select_in_out, o_select_in_oe} = pins_reg[3:2];
   assign o_pdata_oe          = pins_reg[1];
   assign o_pdata             = fwd_data_reg;
   assign o_rdata             = rdata_reg;
   assign o_service_intr_mask = mask_reg;
   assign o_service_intr      = svc_reg;
   assign o_fault_intr        = fault_irq_reg;
   assign o_ack_intr          = ack_irq_reg;
   assign o_dma_req           = dma_req;
   assign o_ldrq_n            = ldrq_n_reg;
   assign o_fifo_count        = fifo.count;
   assign o_fifo_empty        = fifo.empty;
   assign o_fifo_full         = fifo.full;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   sequence s_cmd_taken;
      fwd_pop && ecp_on && fifo.rdata[CMD_BIT];
   endsequence
   property p_hostack_cmd;
      s_cmd_taken |-> ##2 (o_autofd_out == 1'b0);
   endproperty
   a_hostack_cmd: assert property (p_hostack_cmd)   // R2
      else $error("command byte sent with hostack high");

   property p_tc_mask;
      tc_hit |=> mask_reg && o_service_intr && !o_dma_req;
   endproperty
   a_tc_mask: assert property (p_tc_mask)   // R11
      else $error("tc did not interrupt and mask");

   property p_masked_no_req;
      mask_reg |-> !o_dma_req;
   endproperty
   a_masked_no_req: assert property (p_masked_no_req)   // R9
      else $error("dma requested while masked");

   property p_burst;
      (burst_reg == DMA_BURST_MAX) |-> !o_dma_req ##1 (burst_reg == 6'h00);
   endproperty
   a_burst: assert property (p_burst)   // R18
      else $error("dma request held past burst limit");

   property p_reverse_hold;
      (ecp_on && dir_reg) |=> ecp_on;
   endproperty
   a_reverse_hold: assert property (p_reverse_hold)   // R1
      else $error("left ecp while reverse");

   property p_fault;
      ($fell(fault_s) && !i_fault_intr_enable_low) |=> o_fault_intr;
   endproperty
   a_fault: assert property (p_fault)   // R14
      else $error("fault edge missed");

   property p_ack;
      (i_ack_intr_enable && $rose(ack_s)) |=> o_ack_intr;
   endproperty
   a_ack: assert property (p_ack)   // R15
      else $error("ack edge missed");

   property p_open_drain;
      $past(mode_reg == MODE_STD) |-> !o_strobe_out && !o_init_out;
   endproperty
   a_open_drain: assert property (p_open_drain)   // R7
      else $error("push-pull drive in mode 000");

   property p_fwd_service;
      (!mask_reg && !i_dma_request_enable && xfer_on && !dir_reg &&
       fifo.count <= thr) |=> o_service_intr;
   endproperty
   a_fwd_service: assert property (p_fwd_service)   // R12
      else $error("forward service interrupt missing");
endmodule : ecp_port
`default_nettype wire

// File: ecp_periph.sv
`default_nettype none
module ecp_periph (
   input  wire logic       i_clk,    // port clock
   input  wire logic       i_stall,  // hold busy high
   input  wire logic       i_strobe, // strobe pin level
   input  wire logic       i_hack,   // hostack pin
   input  wire logic [7:0] i_data,   // data pins
   output var  logic       o_busy    // busy pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] got[$];
   initial o_busy = 1'h0;
   // take byte on strobe low; stall models a slow peripheral
   always @(posedge i_clk) begin
      if (!i_strobe && !o_busy) begin
         got.push_back({i_hack, i_data});
         o_busy <= 1'h1;
      end else if (i_strobe && o_busy && !i_stall)
         o_busy <= 1'h0;
   end
endmodule : ecp_periph
`default_nettype wire

// File: ecp_port_fifo_service_logic_bench.sv
`default_nettype none
module ecp_port_fifo_service_logic_bench
   import ecp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 1'h0, i_srst = 1'h1, i_direction = 1'h0, stall = 1'h0;
   logic i_mask_wr = 1'h0, i_mask_wdata = 1'h0, i_dma_request_enable = 1'h0;
   logic i_fault_intr_enable_low = 1'h1, i_ack_intr_enable = 1'h0;
   logic sw_n = 1'h1, sel_n = 1'h0, i_data_fifo_port_wr = 1'h0;
   logic i_test_fifo_port_wr = 1'h0, i_command_fifo_port_wr = 1'h0;
   logic i_fifo_rd = 1'h0, i_dma_cyc = 1'h0, i_dma_tc = 1'h0, i_busy, seen;
   logic i_peripheral_ack_low = 1'h1, i_peripheral_fault_low = 1'h1;
   logic [2:0] i_mode = MODE_STD;
   logic [3:0] i_fifo_threshold_field = 4'h3;
   logic [7:0] i_wdata = 8'h00, i_dma_wdata = 8'h00, i_pdata = 8'h00, o_pdata;
   logic [4:0] o_fifo_count;
   logic [7:0] o_rdata;
   logic o_service_intr_mask, o_service_intr, o_fault_intr, o_ack_intr;
   logic o_dma_req, o_ldrq_n, o_fifo_empty, o_strobe_out, o_strobe_oe;
   logic o_autofd_out, o_init_out, o_init_oe, o_select_in_oe;
   int   num_errors = 0, checks = 0, n_fault = 0, n_ack = 0;

   always #4 i_clk = ~i_clk;
   // irq pulses last one cycle; count the high cycles
   always @(posedge i_clk) begin
      n_fault += int'(o_fault_intr);
      n_ack += int'(o_ack_intr);
   end

   ecp_port i_dut (.i_clk, .i_srst, .i_mode, .i_direction, .i_mask_wr,
      .i_mask_wdata, .i_dma_request_enable, .i_fifo_threshold_field,
      .i_fault_intr_enable_low, .i_ack_intr_enable, .i_strobe_sw_n(sw_n),
      .i_autofd_sw_n(sw_n), .i_init_n(sw_n), .i_select_in_n(sel_n),
      .i_data_fifo_port_wr, .i_test_fifo_port_wr, .i_command_fifo_port_wr,
      .i_wdata, .i_fifo_rd, .i_dma_cyc, .i_dma_wdata, .i_dma_tc, .i_pdata,
      .i_busy, .i_peripheral_ack_low, .i_peripheral_fault_low, .o_rdata,
      .o_service_intr_mask, .o_service_intr, .o_fault_intr, .o_ack_intr,
      .o_dma_req, .o_ldrq_n, .o_fifo_count, .o_fifo_empty, .o_fifo_full(),
      .o_pdata, .o_pdata_oe(), .o_strobe_out, .o_strobe_oe, .o_autofd_out,
      .o_autofd_oe(), .o_init_out, .o_init_oe, .o_select_in_out(),
      .o_select_in_oe);
   ecp_periph i_per (.i_clk, .i_stall(stall), .i_hack(o_autofd_out),
      .i_strobe(o_strobe_oe ? o_strobe_out : 1'h1), // pull-up when released
      .i_data(o_pdata), .o_busy(i_busy));

   task chk(input logic [8:0] g, input logic [8:0] e);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   // one host write, command port when cmd is set
   task wr(input logic cmd, input logic [7:0] d);
      @(posedge i_clk);
      i_command_fifo_port_wr <= cmd;
      i_data_fifo_port_wr <= !cmd;
      i_wdata <= d;
      @(posedge i_clk);
      i_command_fifo_port_wr <= 1'h0;
      i_data_fifo_port_wr <= 1'h0;
   endtask : wr
   task mask(input logic v);
      @(posedge i_clk);
      i_mask_wr <= 1'h1;
      i_mask_wdata <= v;
      @(posedge i_clk);
      i_mask_wr <= 1'h0;
   endtask : mask
   task end_of_test;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   // watchdog; tests take well under 1000 cycles
   initial begin
      repeat (5000) @(posedge i_clk);
      num_errors++;
      end_of_test;
   end

   initial begin
      repeat (8) @(posedge i_clk);
      i_srst <= 1'h0;
      repeat (3) @(negedge i_clk);
      chk(o_service_intr_mask, 1'h1);
      chk(o_fifo_empty, 1'h1);
      chk(o_ldrq_n, 1'h1);
      chk({o_init_oe, o_init_out, o_select_in_oe}, 9'h1);
      $display("test reset done");
      @(posedge i_clk);
      i_mode <= MODE_ECP;
      mask(1'h0);
      wr(1'h1, 8'h05);
      wr(1'h0, 8'ha5);
      wr(1'h1, 8'h83);
      wr(1'h0, 8'h3c);
      repeat (100) @(negedge i_clk);
      chk(9'(i_per.got.size()), 9'h004);
      chk(i_per.got[0], 9'h005);
      chk(i_per.got[1], 9'h1a5);
      chk(i_per.got[2], 9'h083);
      chk(i_per.got[3], 9'h13c);
      chk(o_strobe_oe, 1'h1);
      $display("test forward done");
      chk(o_service_intr, 1'h1);
      @(posedge i_clk);
      stall <= 1'h1;
      repeat (6) wr(1'h0, 8'h5a);
      repeat (20) @(negedge i_clk);
      chk(o_fifo_count, 9'h005);
      chk(o_service_intr, 1'h0);
      mask(1'h1);
      @(posedge i_clk);
      stall <= 1'h0;
      repeat (100) @(negedge i_clk);
      chk(o_service_intr, 1'h0);
      mask(1'h0);
      repeat (2) @(negedge i_clk);
      chk(o_service_intr, 1'h1);
      $display("test service done");
      @(posedge i_clk);
      i_dma_request_enable <= 1'h1;
      seen = 1'h1;
      repeat (12) begin
         @(negedge i_clk);
         seen &= o_ldrq_n;
      end
      chk(seen, 1'h0);
      chk(o_dma_req, 1'h1);
      @(posedge i_clk);
      i_dma_cyc <= 1'h1;
      i_dma_wdata <= 8'hc3;
      @(posedge i_clk);
      i_dma_cyc <= 1'h0;
      i_dma_tc <= 1'h1;
      @(posedge i_clk);
      i_dma_tc <= 1'h0;
      repeat (2) @(negedge i_clk);
      chk(o_service_intr_mask, 1'h1);
      chk(o_dma_req, 1'h0);
      $display("test dma done");
      @(posedge i_clk);
      i_dma_request_enable <= 1'h0;
      i_fault_intr_enable_low <= 1'h0;
      i_ack_intr_enable <= 1'h1;
      i_peripheral_ack_low <= 1'h0;
      repeat (8) @(posedge i_clk);
      i_peripheral_fault_low <= 1'h0;
      i_peripheral_ack_low <= 1'h1;
      repeat (8) @(posedge i_clk);
      i_fault_intr_enable_low <= 1'h1;
      repeat (4) @(posedge i_clk);
      i_fault_intr_enable_low <= 1'h0;
      repeat (8) @(negedge i_clk);
      chk(9'(n_fault), 9'h002);
      chk(9'(n_ack), 9'h001);
      $display("test irq done");
      @(posedge i_clk);
      i_mode <= MODE_STD;
      @(posedge i_clk);
      i_mode <= MODE_TEST;
      @(posedge i_clk);
      i_test_fifo_port_wr <= 1'h1;
      @(posedge i_clk);
      i_test_fifo_port_wr <= 1'h0;
      i_fifo_rd <= 1'h1;
      @(posedge i_clk);
      i_fifo_rd <= 1'h0;
      @(negedge i_clk);
      chk(o_rdata, 9'h05a);
      $display("test fifo done");
      end_of_test;
   end
endmodule : ecp_port_fifo_service_logic_bench
`default_nettype wire
